// file: hdl/servo_ref_defs.svh
/*
  Offsets, field positions, reset values, ranges and timing counts of the
  servo reference conditioning block.
  Assumes a 10 MHz aclk and 32-bit AXI4-Lite data.
*/
`ifndef SERVO_REF_DEFS_SVH
`define SERVO_REF_DEFS_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_SPEED_GAIN 6'h04
`define IDX_INTEGRAL_TIME 6'h05
`define IDX_ACCEL_TIME 6'h07
`define IDX_TORQUE_FILTER 6'h17
`define IDX_POS_GAIN 6'h1A
`define IDX_DECEL_TIME 6'h23
`define IDX_SMOOTHING 6'h26
`define IDX_CONTROL 6'h30
`define IDX_MANUAL_OFFSET 6'h31
`define IDX_RAMP_STATE 6'h32
`define IDX_BACKLOG 6'h33

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define CTRL_MODE_BIT 0
`define CTRL_TRIM_BIT 1

// ---------------------------------------------------------------
// reset values and ranges
// ---------------------------------------------------------------
`define RST_SPEED_GAIN 16'h0050
`define RST_INTEGRAL_TIME 16'h0014
`define RST_ACCEL_TIME 16'h0000
`define RST_DECEL_TIME 16'h0000
`define RST_TORQUE_FILTER 16'h0004
`define RST_SMOOTHING 16'h0000
`define RST_POS_GAIN 16'h0028
`define MIN_SPEED_GAIN 16'h0001
`define MAX_SPEED_GAIN 16'h07D0
`define MIN_INTEGRAL_TIME 16'h0002
`define MAX_INTEGRAL_TIME 16'h2710
`define MAX_RAMP_TIME 16'h2710
`define MAX_TORQUE_FILTER 16'h00FA
`define MAX_SMOOTHING 16'h0280
`define MIN_POS_GAIN 16'h0001
`define MAX_POS_GAIN 16'h00C8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_MHZ 10
`define TICK_US 100
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define TICKS_PER_MS (1000 / `TICK_US)
`define MAX_SPEED_RPM 4500

`endif

// file: hdl/servo_ref_pkg.sv
/*
  Types of the servo reference conditioning block.
  Assumes servo_ref_defs.svh for the numbers.
*/
package servo_ref_pkg;

  typedef enum logic {
    mode_speed_torque,
    mode_position
  } ctrl_mode_e;

  typedef struct packed {
    logic valid;
    logic [15:0] speed_gain;
    logic [15:0] integral_time;
    logic [15:0] position_gain;
  } tune_s;

  typedef struct packed {
    logic [15:0] velocity_gain;
    logic [15:0] integral_time;
    logic [15:0] position_loop_gain;
  } gains_s;

endpackage : servo_ref_pkg

// file: hdl/servo_reference_conditioning.sv
/*
  Speed ramp, pulse smoother, torque filter, loop gain settings and
  offset trim of a servo drive, with an AXI4-Lite register slave.
  Assumes references come from same-clock logic, one sample per tick.
*/
`timescale 1ns/1ps
`include "servo_ref_defs.svh"

module servo_reference_conditioning #(
  parameter int ADDR_W = 8,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic signed [15:0] speed_ref_raw,
  input wire logic signed [15:0] torque_ref_in,
  input wire logic signed [15:0] pos_pulse_in,
  input wire servo_ref_pkg::tune_s tune,
  output logic signed [15:0] speed_ref_out,
  output logic signed [15:0] torque_ref_out,
  output logic signed [15:0] pos_pulse_out,
  output servo_ref_pkg::gains_s gains,
  output logic tick
);
  import servo_ref_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  function automatic logic signed [32:0] sdiv(input logic signed [32:0] a,
                                              input logic signed [23:0] b);
    logic signed [32:0] bx;
    bx = 33'(b);
    return a / bx;
  endfunction : sdiv

  function automatic logic signed [15:0] sat16(input logic signed [32:0] v);
    if (v > 33'sd32767) return 16'sh7FFF;
    if (v < -33'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction : sat16

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] speed_gain, next_speed_gain;
  logic [15:0] integral_time, next_integral_time;
  logic [15:0] accel_ramp_time, next_accel_ramp_time;
  logic [15:0] decel_ramp_time, next_decel_ramp_time;
  logic [15:0] torque_filter_time, next_torque_filter_time;
  logic [15:0] pulse_smoothing_time, next_pulse_smoothing_time;
  logic [15:0] position_loop_gain, next_position_loop_gain;
  logic signed [15:0] offset, next_offset;
  ctrl_mode_e mode, next_mode;
  logic trim_pend, next_trim_pend;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic aw_full, next_aw_full;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic w_full, next_w_full;
  logic bvalid_q, next_bvalid;
  logic [1:0] bresp_q, next_bresp;
  logic rvalid_q, next_rvalid;
  logic [1:0] rresp_q, next_rresp;
  logic [31:0] rdata_q, next_rdata;

  logic [15:0] tick_cnt, next_tick_cnt;
  logic signed [31:0] ramp_acc, next_ramp_acc;
  logic signed [31:0] backlog, next_backlog;
  logic signed [31:0] trq_acc, next_trq_acc;
  logic signed [15:0] speed_q, next_speed;
  logic signed [15:0] torque_q, next_torque;
  logic signed [15:0] pulse_q, next_pulse;
  logic tick_q, next_tick;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  function automatic logic mapped(input logic [5:0] idx);
    case (idx)
      `IDX_SPEED_GAIN, `IDX_INTEGRAL_TIME, `IDX_ACCEL_TIME, `IDX_TORQUE_FILTER,
      `IDX_POS_GAIN, `IDX_DECEL_TIME, `IDX_SMOOTHING, `IDX_CONTROL,
      `IDX_MANUAL_OFFSET, `IDX_RAMP_STATE, `IDX_BACKLOG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : mapped

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  logic [5:0] widx;
  logic [5:0] ridx;
  logic [15:0] wv;
  logic [15:0] ctrl_rd;

  assign awready = !aw_full;
  assign wready = !w_full;
  assign arready = !rvalid_q;
  assign widx = aw_addr[7:2];
  assign ridx = araddr[7:2];
  assign ctrl_rd = {14'h0000, trim_pend, (mode == mode_position)};

  always_comb begin
    next_speed_gain = speed_gain;
    next_integral_time = integral_time;
    next_accel_ramp_time = accel_ramp_time;
    next_decel_ramp_time = decel_ramp_time;
    next_torque_filter_time = torque_filter_time;
    next_pulse_smoothing_time = pulse_smoothing_time;
    next_position_loop_gain = position_loop_gain;
    next_offset = offset;
    next_mode = mode;
    next_trim_pend = trim_pend;
    next_aw_addr = aw_addr;
    next_aw_full = aw_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_w_full = w_full;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    next_rvalid = rvalid_q;
    next_rresp = rresp_q;
    next_rdata = rdata_q;
    wv = 16'h0000;
    // automatic trim captures the raw reference as offset at a tick
    if (trim_pend && tick) begin
      next_offset = speed_ref_raw;
      next_trim_pend = 1'b0;
    end
    if (awvalid && !aw_full) begin
      next_aw_addr = awaddr;
      next_aw_full = 1'b1;
    end
    if (wvalid && !w_full) begin
      next_w_data = wdata;
      next_w_strb = wstrb;
      next_w_full = 1'b1;
    end
    if (aw_full && w_full && !bvalid_q) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(widx) ? 2'h0 : 2'h2;
      case (widx)
        `IDX_SPEED_GAIN: begin
          wv = merge(speed_gain, w_data, w_strb);
          next_speed_gain = clamp16(wv, `MIN_SPEED_GAIN, `MAX_SPEED_GAIN);
        end
        `IDX_INTEGRAL_TIME: begin
          wv = merge(integral_time, w_data, w_strb);
          next_integral_time = clamp16(wv, `MIN_INTEGRAL_TIME, `MAX_INTEGRAL_TIME);
        end
        `IDX_ACCEL_TIME: begin
          wv = merge(accel_ramp_time, w_data, w_strb);
          next_accel_ramp_time = clamp16(wv, 16'h0000, `MAX_RAMP_TIME);
        end
        `IDX_DECEL_TIME: begin
          wv = merge(decel_ramp_time, w_data, w_strb);
          next_decel_ramp_time = clamp16(wv, 16'h0000, `MAX_RAMP_TIME);
        end
        `IDX_TORQUE_FILTER: begin
          wv = merge(torque_filter_time, w_data, w_strb);
          next_torque_filter_time = clamp16(wv, 16'h0000, `MAX_TORQUE_FILTER);
        end
        `IDX_SMOOTHING: begin
          wv = merge(pulse_smoothing_time, w_data, w_strb);
          next_pulse_smoothing_time = clamp16(wv, 16'h0000, `MAX_SMOOTHING);
        end
        `IDX_POS_GAIN: begin
          wv = merge(position_loop_gain, w_data, w_strb);
          next_position_loop_gain = clamp16(wv, `MIN_POS_GAIN, `MAX_POS_GAIN);
        end
        `IDX_MANUAL_OFFSET: begin
          next_offset = merge(offset, w_data, w_strb);
        end
        `IDX_CONTROL: begin
          if (w_strb[0]) begin
            next_mode = w_data[`CTRL_MODE_BIT] ? mode_position : mode_speed_torque;
            if (w_data[`CTRL_TRIM_BIT]) begin
              next_trim_pend = 1'b1;
            end
          end
        end
        default: begin
          wv = 16'h0000;
        end
      endcase
    end
    // autotuning results override a software write in the same cycle
    if (tune.valid) begin
      next_speed_gain = clamp16(tune.speed_gain, `MIN_SPEED_GAIN, `MAX_SPEED_GAIN);
      next_integral_time = clamp16(tune.integral_time, `MIN_INTEGRAL_TIME,
                                   `MAX_INTEGRAL_TIME);
      next_position_loop_gain = clamp16(tune.position_gain, `MIN_POS_GAIN,
                                        `MAX_POS_GAIN);
    end
    if (bvalid_q && bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid_q && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && !rvalid_q) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(ridx) ? 2'h0 : 2'h2;
      case (ridx)
        `IDX_SPEED_GAIN: next_rdata = {16'h0000, speed_gain};
        `IDX_INTEGRAL_TIME: next_rdata = {16'h0000, integral_time};
        `IDX_ACCEL_TIME: next_rdata = {16'h0000, accel_ramp_time};
        `IDX_DECEL_TIME: next_rdata = {16'h0000, decel_ramp_time};
        `IDX_TORQUE_FILTER: next_rdata = {16'h0000, torque_filter_time};
        `IDX_SMOOTHING: next_rdata = {16'h0000, pulse_smoothing_time};
        `IDX_POS_GAIN: next_rdata = {16'h0000, position_loop_gain};
        `IDX_MANUAL_OFFSET: next_rdata = {16'h0000, offset};
        `IDX_CONTROL: next_rdata = {16'h0000, ctrl_rd};
        `IDX_RAMP_STATE: next_rdata = {16'h0000, speed_q};
        `IDX_BACKLOG: next_rdata = backlog;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_gain <= `RST_SPEED_GAIN;
      integral_time <= `RST_INTEGRAL_TIME;
      accel_ramp_time <= `RST_ACCEL_TIME;
      decel_ramp_time <= `RST_DECEL_TIME;
      torque_filter_time <= `RST_TORQUE_FILTER;
      pulse_smoothing_time <= `RST_SMOOTHING;
      position_loop_gain <= `RST_POS_GAIN;
      offset <= 16'sh0000;
      mode <= mode_speed_torque;
      trim_pend <= 1'b0;
      aw_addr <= '0;
      aw_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_full <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h00000000;
    end else begin
      speed_gain <= next_speed_gain;
      integral_time <= next_integral_time;
      accel_ramp_time <= next_accel_ramp_time;
      decel_ramp_time <= next_decel_ramp_time;
      torque_filter_time <= next_torque_filter_time;
      pulse_smoothing_time <= next_pulse_smoothing_time;
      position_loop_gain <= next_position_loop_gain;
      offset <= next_offset;
      mode <= next_mode;
      trim_pend <= next_trim_pend;
      aw_addr <= next_aw_addr;
      aw_full <= next_aw_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      w_full <= next_w_full;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rresp_q <= next_rresp;
      rdata_q <= next_rdata;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign gains = '{velocity_gain: speed_gain, integral_time: integral_time,
                   position_loop_gain: position_loop_gain};

  // ---------------------------------------------------------------
  // reference datapath, one step per control tick
  // ---------------------------------------------------------------
  logic tick_now;
  logic signed [32:0] target;
  logic signed [32:0] step;
  logic signed [32:0] sum;
  logic signed [32:0] bl;
  logic signed [32:0] q;
  logic signed [15:0] pout;
  logic [15:0] ramp_t;
  logic up;
  logic away;

  assign tick_now = (tick_cnt == 16'(TICK_CYCLES - 1));

  always_comb begin
    next_tick_cnt = tick_now ? 16'h0000 : tick_cnt + 16'h0001;
    next_tick = tick_now;
    next_ramp_acc = ramp_acc;
    next_backlog = backlog;
    next_trq_acc = trq_acc;
    next_speed = speed_q;
    next_torque = torque_q;
    next_pulse = pulse_q;
    target = 33'($signed({sat16(33'(speed_ref_raw) - 33'(offset)), 16'h0000}));
    up = (target > 33'(ramp_acc));
    away = up ? (ramp_acc >= 0) : (ramp_acc <= 0);
    ramp_t = away ? accel_ramp_time : decel_ramp_time;
    step = sdiv(33'(`MAX_SPEED_RPM) <<< 16, 24'({8'h00, ramp_t}) * 24'(`TICKS_PER_MS));
    sum = 33'sd0;
    bl = 33'(backlog) + 33'(pos_pulse_in);
    q = 33'sd0;
    pout = 16'sh0000;
    if (tick_now) begin
      if (mode == mode_position || ramp_t == 16'h0000) begin
        next_ramp_acc = target[31:0];
      end else if (up) begin
        sum = 33'(ramp_acc) + step;
        next_ramp_acc = (sum > target) ? target[31:0] : sum[31:0];
      end else begin
        sum = 33'(ramp_acc) - step;
        next_ramp_acc = (sum < target) ? target[31:0] : sum[31:0];
      end
      next_speed = next_ramp_acc[31:16];
      if (mode == mode_position) begin
        if (pulse_smoothing_time == 16'h0000) begin
          q = bl;
        end else begin
          q = sdiv(bl, 24'({8'h00, pulse_smoothing_time}) + 24'sd1);
          if (q == 33'sd0 && bl != 33'sd0) begin
            q = (bl > 0) ? 33'sd1 : -33'sd1;
          end
        end
        pout = sat16(q);
        next_backlog = 32'(bl - 33'(pout));
      end
      next_pulse = pout;
      if (torque_filter_time == 16'h0000) begin
        next_trq_acc = {torque_ref_in, 16'h0000};
      end else begin
        q = sdiv(33'($signed({torque_ref_in, 16'h0000})) - 33'(trq_acc),
                 24'({8'h00, torque_filter_time}) + 24'sd1);
        next_trq_acc = trq_acc + q[31:0];
      end
      next_torque = next_trq_acc[31:16];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 16'h0000;
      tick_q <= 1'b0;
      ramp_acc <= 32'sh00000000;
      backlog <= 32'sh00000000;
      trq_acc <= 32'sh00000000;
      speed_q <= 16'sh0000;
      torque_q <= 16'sh0000;
      pulse_q <= 16'sh0000;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick_q <= next_tick;
      ramp_acc <= next_ramp_acc;
      backlog <= next_backlog;
      trq_acc <= next_trq_acc;
      speed_q <= next_speed;
      torque_q <= next_torque;
      pulse_q <= next_pulse;
    end
  end

  assign tick = tick_q;
  assign speed_ref_out = speed_q;
  assign torque_ref_out = torque_q;
  assign pos_pulse_out = pulse_q;

endmodule : servo_reference_conditioning

// file: testbench/servo_ref_host_model.sv
/*
  Host controller model: speed, torque and pulse references.
  Assumes the block's tick marks each control cycle.
*/
`timescale 1ns/1ps

module servo_ref_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic signed [15:0] speed_set,
  input wire logic signed [15:0] torque_set,
  input wire logic signed [15:0] pulse_set,
  output logic signed [15:0] speed_ref_raw,
  output logic signed [15:0] torque_ref_in,
  output logic signed [15:0] pos_pulse_in
);
  // new values once a control cycle, held a full cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_ref_raw <= 16'sh0000;
      torque_ref_in <= 16'sh0000;
      pos_pulse_in <= 16'sh0000;
    end else if (tick) begin
      speed_ref_raw <= speed_set;
      torque_ref_in <= torque_set;
      pos_pulse_in <= pulse_set;
    end
  end
  // model never closes a position loop, so it never asks for automatic trim
endmodule : servo_ref_host_model

// file: testbench/servo_reference_conditioning_properties.sv
/*
  Port checker of the reference conditioning block.
  Assumes binding into servo_reference_conditioning, one clock.
*/
`timescale 1ns/1ps
`include "servo_ref_defs.svh"

module servo_reference_conditioning_properties #(
  parameter int ADDR_W = 8,
  parameter int TICK_CYCLES = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic signed [15:0] speed_ref_out,
  input wire logic signed [15:0] torque_ref_out,
  input wire logic signed [15:0] pos_pulse_out,
  input servo_ref_pkg::tune_s tune,
  input servo_ref_pkg::gains_s gains,
  input wire logic tick
);
  import servo_ref_pkg::*;
  int gap;
  logic seen;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // cycles between control ticks
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 0;
      seen <= 1'b0;
    end else begin
      gap <= tick ? 1 : gap + 1;
      seen <= seen | tick;
    end
  end
  sequence s_aw_w_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_ar_taken;
    arvalid && arready;
  endsequence
  chk_write_answer: assert property (s_aw_w_taken |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after request");
  chk_read_answer: assert property (s_ar_taken |=> rvalid && !arready)
    else $error("read response not one cycle after request");
  chk_write_block: assert property (s_aw_w_taken |=> !awready && !wready)
    else $error("write accepted while previous one held");
  chk_bresp_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
  chk_rvalid_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read response not released");
  chk_tick_period: assert property (seen && tick |-> gap == TICK_CYCLES)
    else $error("control tick period wrong");
  chk_out_on_tick: assert property (!tick |-> $stable(speed_ref_out) &&
      $stable(torque_ref_out) && $stable(pos_pulse_out))
    else $error("reference output moved off tick");
  chk_tune_load: assert property (tune.valid &&
      tune.speed_gain inside {[`MIN_SPEED_GAIN:`MAX_SPEED_GAIN]} &&
      tune.integral_time inside {[`MIN_INTEGRAL_TIME:`MAX_INTEGRAL_TIME]} &&
      tune.position_gain inside {[`MIN_POS_GAIN:`MAX_POS_GAIN]} |=>
      gains.velocity_gain == $past(tune.speed_gain) &&
      gains.integral_time == $past(tune.integral_time) &&
      gains.position_loop_gain == $past(tune.position_gain))
    else $error("autotune values not loaded");
  chk_gain_range: assert property (
      gains.velocity_gain inside {[`MIN_SPEED_GAIN:`MAX_SPEED_GAIN]} &&
      gains.integral_time inside {[`MIN_INTEGRAL_TIME:`MAX_INTEGRAL_TIME]})
    else $error("loop gain setting out of range");
endmodule : servo_reference_conditioning_properties

bind servo_reference_conditioning servo_reference_conditioning_properties #(
  .ADDR_W(ADDR_W), .TICK_CYCLES(TICK_CYCLES)) i_servo_reference_conditioning_properties (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .rvalid, .rready, .speed_ref_out, .torque_ref_out,
  .pos_pulse_out, .tune, .gains, .tick);

// file: testbench/servo_reference_conditioning_tb_top.sv
/*
  Self-checking bench of the reference conditioning block.
  Assumes the host model and the bound checker beside it.
*/
`timescale 1ns/1ps
`include "servo_ref_defs.svh"

module servo_reference_conditioning_tb_top;
  import servo_ref_pkg::*;
  localparam int TICKS = 10;
  localparam int LIMIT = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, tick;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic signed [15:0] speed_ref_raw, torque_ref_in, pos_pulse_in;
  logic signed [15:0] speed_ref_out, torque_ref_out, pos_pulse_out;
  logic signed [15:0] speed_set = 16'sh0, torque_set = 16'sh0, pulse_set = 16'sh0;
  tune_s tune = '0;
  gains_s gains;
  int miscompares = 0, checks = 0, cycles = 0;
  always #50 aclk = ~aclk;
  servo_reference_conditioning #(.TICK_CYCLES(TICKS)) i_servo_reference_conditioning (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .speed_ref_raw, .torque_ref_in, .pos_pulse_in, .tune, .speed_ref_out,
    .torque_ref_out, .pos_pulse_out, .gains, .tick);
  servo_ref_host_model i_servo_ref_host_model (.aclk, .aresetn, .tick, .speed_set,
    .torque_set, .pulse_set, .speed_ref_raw, .torque_ref_in, .pos_pulse_in);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic axi_write(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic a, w, b;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_write
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic a, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge aclk);
      a = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    cmp(d, exp);
    cmp(r, er);
  endtask : rd_chk
  task automatic next_tick();
    do @(negedge aclk); while (!tick);
  endtask : next_tick
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    cmp(gains.velocity_gain, 16'h0050);
    cmp(gains.integral_time, 16'h0014);
    rd_chk(`IDX_SPEED_GAIN, 32'h50, 2'b00);
    rd_chk(`IDX_INTEGRAL_TIME, 32'h14, 2'b00);
    rd_chk(`IDX_ACCEL_TIME, 32'h0, 2'b00);
    rd_chk(`IDX_DECEL_TIME, 32'h0, 2'b00);
    rd_chk(`IDX_TORQUE_FILTER, 32'h4, 2'b00);
    rd_chk(`IDX_SMOOTHING, 32'h0, 2'b00);
    rd_chk(6'h3F, 32'h0, 2'b10);
  endtask : t_reset_values
  task automatic t_autotune();
    logic [1:0] r;
    @(posedge aclk);
    tune <= '{1'b1, 16'h012C, 16'h0032, 16'h003C};
    @(posedge aclk);
    tune <= '0;
    @(negedge aclk);
    cmp(gains.velocity_gain, 16'h012C);
    cmp(gains.integral_time, 16'h0032);
    cmp(gains.position_loop_gain, 16'h003C);
    rd_chk(`IDX_POS_GAIN, 32'h3C, 2'b00);
    axi_write(`IDX_SPEED_GAIN, 32'hBB8, r);
    rd_chk(`IDX_SPEED_GAIN, 32'h7D0, 2'b00);
    axi_write(`IDX_INTEGRAL_TIME, 32'h1, r);
    rd_chk(`IDX_INTEGRAL_TIME, 32'h2, 2'b00);
    axi_write(6'h3F, 32'h1, r);
    cmp(r, 2'b10);
  endtask : t_autotune
  task automatic t_speed_ramp();
    logic [1:0] r;
    axi_write(`IDX_ACCEL_TIME, 32'h1, r);
    axi_write(`IDX_DECEL_TIME, 32'h2, r);
    next_tick();
    speed_set <= 16'sh0384;
    next_tick();
    cmp(speed_ref_out, 16'sh01C2);
    next_tick();
    cmp(speed_ref_out, 16'sh0384);
    speed_set <= 16'sh0000;
    next_tick();
    cmp(speed_ref_out, 16'sh02A3);
    next_tick();
    cmp(speed_ref_out, 16'sh01C2);
    axi_write(`IDX_ACCEL_TIME, 32'h0, r);
    axi_write(`IDX_DECEL_TIME, 32'h0, r);
    speed_set <= -16'sh012C;
    next_tick();
    next_tick();
    cmp(speed_ref_out, -16'sh012C);
    rd_chk(`IDX_RAMP_STATE, 32'h0000FED4, 2'b00);
  endtask : t_speed_ramp
  task automatic t_torque_filter();
    logic [1:0] r;
    next_tick();
    torque_set <= 16'sh03E8;
    next_tick();
    cmp(torque_ref_out, 16'sh00C8);
    next_tick();
    cmp(torque_ref_out, 16'sh0168);
    axi_write(`IDX_TORQUE_FILTER, 32'h0, r);
    next_tick();
    cmp(torque_ref_out, 16'sh03E8);
  endtask : t_torque_filter
  task automatic t_smoother();
    logic [1:0] r;
    int sum;
    axi_write(`IDX_CONTROL, 32'h1, r);
    axi_write(`IDX_SMOOTHING, 32'h3, r);
    next_tick();
    pulse_set <= 16'sh000A;
    next_tick();
    pulse_set <= 16'sh0000;
    cmp(pos_pulse_out, 16'sh0002);
    sum = pos_pulse_out;
    repeat (12) begin
      next_tick();
      sum += pos_pulse_out;
    end
    cmp(sum, 32'hA);
    rd_chk(`IDX_BACKLOG, 32'h0, 2'b00);
    axi_write(`IDX_SMOOTHING, 32'h0, r);
    next_tick();
    pulse_set <= -16'sh0007;
    next_tick();
    pulse_set <= 16'sh0000;
    cmp(pos_pulse_out, -16'sh0007);
  endtask : t_smoother
  task automatic t_offset_trim();
    logic [1:0] r;
    axi_write(`IDX_CONTROL, 32'h0, r);
    speed_set <= 16'sh007B;
    next_tick();
    next_tick();
    cmp(speed_ref_out, 16'sh007B);
    axi_write(`IDX_CONTROL, 32'h2, r);
    next_tick();
    next_tick();
    cmp(speed_ref_out, 16'sh0000);
    rd_chk(`IDX_CONTROL, 32'h0, 2'b00);
    axi_write(`IDX_MANUAL_OFFSET, 32'h64, r);
    next_tick();
    next_tick();
    cmp(speed_ref_out, 16'sh0017);
  endtask : t_offset_trim
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_autotune();
    t_speed_ramp();
    t_torque_filter();
    t_smoother();
    t_offset_trim();
    close_out();
  end
endmodule : servo_reference_conditioning_tb_top
